// ===== rtl/sspc_map.svh
`ifndef SSPC_MAP_SVH
`define SSPC_MAP_SVH
`define SSPC_OFS_SOFT_RESET 8'h01
`define SSPC_OFS_SLEEP 8'h02
`define SSPC_OFS_PWRDN 8'h05
`define SSPC_RST_SLEEP 8'h00
`define SSPC_RST_PWRDN 8'h05
`define SSPC_SLEEP_WMASK 8'hFD
`define SSPC_PWRDN_WMASK 8'h3F
`define SSPC_SOFT_RESET_BIT 0
`define SSPC_GROUP_ADDR 7'h4C
`define SSPC_CLK_NS 25
`define SSPC_TICK_US 500
`define SSPC_VREF_T0_US 3500
`define SSPC_VREF_T1_US 10000
`define SSPC_VREF_T2_US 50000
`define SSPC_VREF_T3_US 100000
`define SSPC_INCAP_T0_US 2500
`define SSPC_INCAP_T1_US 12500
`define SSPC_INCAP_T2_US 25000
`define SSPC_INCAP_T3_US 50000
`define SSPC_HOLD_T0_US 30000
`define SSPC_HOLD_T1_US 25000
`define SSPC_HOLD_T2_US 10000
`define SSPC_HOLD_T3_US 5000
`endif

// ===== rtl/sspc_pkg.sv
package sspc_pkg;
  typedef struct packed {
    logic analog_regulator_source_sel;
    logic [1:0] spare;
    logic [1:0] reference_precharge_time;
    logic group_address_enable;
    logic fixed_zero;
    logic awake_enable;
  } sspc_sleep_t;

  typedef struct packed {
    logic [1:0] fixed_zero;
    logic [1:0] input_cap_precharge_time;
    logic [1:0] power_down_policy;
    logic [1:0] core_supply_hold_time;
  } sspc_pwrdn_t;

  typedef struct packed {
    logic core_regulator_en;
    logic analog_regulator_source_sel;
    logic vref_charging;
    logic incap_charging;
    logic awake;
    logic clean_shutdown_req;
  } sspc_pwr_t;

  typedef enum logic [2:0] {ST_SLEEP, ST_CHARGE, ST_ACTIVE, ST_HOLD, ST_OFF} sspc_state_t;
endpackage : sspc_pkg

// ===== rtl/sspc_power_ctrl.sv
// What this block does
// R1: Sleep register bit 7 picks external or on-chip analog supply source.
// R2: Reference precharge code 0..3 gives 3.5, 10, 50, 100 ms.
// R3: Group address enable set: answer on fixed address 1001100.
// R4: Group address enable clear: address is STRAP_BASE with strap pins as its low 2 bits.
// R5: Awake enable bit 0 resets to 0 (sleep); writing 1 wakes device.
// R6: Input capacitor precharge code 0..3 gives 2.5, 12.5, 25, 50 ms.
// R7: Policy 0: core regulator off at once when shutdown pin asserts.
// R8: Policy 1: core regulator held, forced off when keep-alive expires.
// R9: Policy 2: held until clean shutdown completes; code 3 reserved.
// R10: Hold time code 0..3 gives 30, 25, 10, 5 ms keep-alive.
// R11: Power-down control register at 0x05 resets to 05h.
// R12: Self-clearing soft reset returns all registers to defaults.
// R13: Durations timed by counters from a fixed reference tick.
`timescale 1ns/10ps
`include "sspc_map.svh"

module sspc_power_ctrl #(
  parameter int TICK_CYC = `SSPC_TICK_US * 1000 / `SSPC_CLK_NS,
  parameter logic [4:0] STRAP_BASE = 5'h0A
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Device pins and core handshake
  input wire logic i_shutdown_pin_n,
  input wire logic [1:0] i_addr_strap,
  input wire logic i_clean_done,
  // Power and address outputs
  output logic [6:0] o_i2c_slave_addr,
  output sspc_pkg::sspc_pwr_t o_pwr
);
  localparam int PW = $clog2(TICK_CYC + 1);

  function automatic logic [7:0] sspc_pick(input logic [1:0] code, input int t0,
                                           input int t1, input int t2, input int t3);
    int t;
    t = (code == 2'h0) ? t0 : (code == 2'h1) ? t1 : (code == 2'h2) ? t2 : t3;
    return 8'(t / `SSPC_TICK_US);
  endfunction : sspc_pick

  sspc_pkg::sspc_sleep_t sleep_reg;
  sspc_pkg::sspc_pwrdn_t pwrdn_reg;
  sspc_pkg::sspc_state_t state_reg, state_next;
  sspc_pkg::sspc_pwr_t pwr_reg, pwr_next;
  logic [1:0] strap_reg;
  logic [6:0] addr_reg;
  logic [7:0] rdata_reg;
  logic [PW-1:0] presc_reg;
  logic [7:0] vref_cnt_reg, vref_cnt_next;
  logic [7:0] incap_cnt_reg, incap_cnt_next;
  logic [7:0] hold_cnt_reg, hold_cnt_next;

  // Register decode
  wire sel_soft = (i_reg_addr == `SSPC_OFS_SOFT_RESET);
  wire sel_sleep = (i_reg_addr == `SSPC_OFS_SLEEP);
  wire sel_pwrdn = (i_reg_addr == `SSPC_OFS_PWRDN);
  wire soft_rst = i_reg_wr && sel_soft && i_reg_wdata[`SSPC_SOFT_RESET_BIT];
  wire wr_sleep = i_reg_wr && sel_sleep;
  wire wr_pwrdn = i_reg_wr && sel_pwrdn;
  wire [7:0] rd_mux = sel_sleep ? sleep_reg : sel_pwrdn ? pwrdn_reg : 8'h00;

  wire pin_low = !i_shutdown_pin_n;
  wire [1:0] policy = pwrdn_reg.power_down_policy;
  wire hold_policy = (policy == 2'h1) || (policy == 2'h2);
  wire awake = sleep_reg.awake_enable;
  wire tick = (presc_reg == PW'(TICK_CYC - 1));
  wire load_charge = (state_next == sspc_pkg::ST_CHARGE) && (state_reg != sspc_pkg::ST_CHARGE);
  wire load_hold = (state_next == sspc_pkg::ST_HOLD) && (state_reg != sspc_pkg::ST_HOLD);
  wire charge_done = (vref_cnt_reg == 8'h00) && (incap_cnt_reg == 8'h00);
  wire hold_expired = (policy == 2'h1) && (hold_cnt_reg == 8'h00);
  wire [6:0] addr_next = sleep_reg.group_address_enable ? `SSPC_GROUP_ADDR :
                         {STRAP_BASE, strap_reg}; // [R3] [R4]

  // Soft reset is a pulse, never stored, so its bit reads back as zero
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || soft_rst) begin // [R12]
      sleep_reg <= `SSPC_RST_SLEEP; // [R5]
      pwrdn_reg <= `SSPC_RST_PWRDN; // [R11]
    end else begin
      if (wr_sleep) begin
        sleep_reg <= i_reg_wdata & `SSPC_SLEEP_WMASK;
      end
      if (wr_pwrdn) begin
        pwrdn_reg <= i_reg_wdata & `SSPC_PWRDN_WMASK;
      end
    end
  end

  // Straps are sampled while reset is held
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      strap_reg <= i_addr_strap;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
      addr_reg <= 7'h00;
    end else begin
      rdata_reg <= i_reg_rd ? rd_mux : rdata_reg;
      addr_reg <= addr_next;
    end
  end

  // Prescaler restarts on every load so a duration never starts mid-tick
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || tick || load_charge || load_hold) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + PW'(1); // [R13]
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sspc_pkg::ST_SLEEP, sspc_pkg::ST_CHARGE, sspc_pkg::ST_ACTIVE: begin
        if (pin_low) begin
          // Reserved policy 3 takes the safe path: off at once
          state_next = hold_policy ? sspc_pkg::ST_HOLD : sspc_pkg::ST_OFF; // [R7] [R9]
        end else if (!awake) begin
          state_next = sspc_pkg::ST_SLEEP; // [R5]
        end else if (state_reg == sspc_pkg::ST_SLEEP) begin
          state_next = sspc_pkg::ST_CHARGE;
        end else if (state_reg == sspc_pkg::ST_CHARGE && charge_done) begin
          state_next = sspc_pkg::ST_ACTIVE;
        end
      end
      sspc_pkg::ST_HOLD: begin
        if (!pin_low) begin
          state_next = sspc_pkg::ST_SLEEP;
        end else if (!hold_policy || i_clean_done || hold_expired) begin
          state_next = sspc_pkg::ST_OFF; // [R8] [R9]
        end
      end
      sspc_pkg::ST_OFF: begin
        if (!pin_low) begin
          state_next = sspc_pkg::ST_SLEEP;
        end
      end
      default: state_next = sspc_pkg::ST_SLEEP;
    endcase
  end

  always_comb begin
    vref_cnt_next = vref_cnt_reg;
    incap_cnt_next = incap_cnt_reg;
    hold_cnt_next = hold_cnt_reg;
    if (load_charge) begin
      vref_cnt_next = sspc_pick(sleep_reg.reference_precharge_time, `SSPC_VREF_T0_US,
                                `SSPC_VREF_T1_US, `SSPC_VREF_T2_US, `SSPC_VREF_T3_US); // [R2]
      incap_cnt_next = sspc_pick(pwrdn_reg.input_cap_precharge_time, `SSPC_INCAP_T0_US,
                                 `SSPC_INCAP_T1_US, `SSPC_INCAP_T2_US, `SSPC_INCAP_T3_US); // [R6]
    end else if (tick) begin
      vref_cnt_next = (vref_cnt_reg != 8'h00) ? vref_cnt_reg - 8'h01 : 8'h00; // [R13]
      incap_cnt_next = (incap_cnt_reg != 8'h00) ? incap_cnt_reg - 8'h01 : 8'h00;
    end
    if (load_hold) begin
      hold_cnt_next = sspc_pick(pwrdn_reg.core_supply_hold_time, `SSPC_HOLD_T0_US,
                                `SSPC_HOLD_T1_US, `SSPC_HOLD_T2_US, `SSPC_HOLD_T3_US); // [R10]
    end else if (tick && hold_cnt_reg != 8'h00) begin
      hold_cnt_next = hold_cnt_reg - 8'h01;
    end
  end

  always_comb begin
    pwr_next.core_regulator_en = (state_next != sspc_pkg::ST_OFF); // [R7]
    pwr_next.analog_regulator_source_sel = sleep_reg.analog_regulator_source_sel; // [R1]
    pwr_next.vref_charging = (state_next == sspc_pkg::ST_CHARGE) && (vref_cnt_next != 8'h00);
    pwr_next.incap_charging = (state_next == sspc_pkg::ST_CHARGE) && (incap_cnt_next != 8'h00);
    pwr_next.awake = (state_next == sspc_pkg::ST_ACTIVE);
    pwr_next.clean_shutdown_req = (state_next == sspc_pkg::ST_HOLD);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg <= sspc_pkg::ST_SLEEP;
      vref_cnt_reg <= 8'h00;
      incap_cnt_reg <= 8'h00;
      hold_cnt_reg <= 8'h00;
      pwr_reg <= 6'h20;
    end else begin
      state_reg <= state_next;
      vref_cnt_reg <= vref_cnt_next;
      incap_cnt_reg <= incap_cnt_next;
      hold_cnt_reg <= hold_cnt_next;
      pwr_reg <= pwr_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_i2c_slave_addr = addr_reg;
  assign o_pwr = pwr_reg;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  property p_src_sel;
    (wr_sleep && !soft_rst) |=> ##1 o_pwr.analog_regulator_source_sel == $past(i_reg_wdata[7], 2);
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("supply source mismatch"); // [R1]

  property p_vref_time;
    (load_charge && sleep_reg.reference_precharge_time == 2'h0) |=> vref_cnt_reg == 8'h07;
  endproperty
  a_vref_time: assert property (p_vref_time) else $error("vref precharge count wrong"); // [R2]

  property p_group_addr;
    sleep_reg.group_address_enable |=> o_i2c_slave_addr == 7'h4C;
  endproperty
  a_group_addr: assert property (p_group_addr) else $error("group address wrong"); // [R3]

  property p_strap_addr;
    !sleep_reg.group_address_enable |=> o_i2c_slave_addr[1:0] == strap_reg;
  endproperty
  a_strap_addr: assert property (p_strap_addr) else $error("strap address wrong"); // [R4]

  property p_sleep;
    (!awake && i_shutdown_pin_n && state_reg == sspc_pkg::ST_ACTIVE) |=> !o_pwr.awake;
  endproperty
  a_sleep: assert property (p_sleep) else $error("awake while sleep selected"); // [R5]

  property p_incap_time;
    (load_charge && pwrdn_reg.input_cap_precharge_time == 2'h3) |=> incap_cnt_reg == 8'h64;
  endproperty
  a_incap_time: assert property (p_incap_time) else $error("incap count wrong"); // [R6]

  property p_off_now;
    (pin_low && policy == 2'h0 && state_reg != sspc_pkg::ST_HOLD) |=> !o_pwr.core_regulator_en;
  endproperty
  a_off_now: assert property (p_off_now) else $error("core not off at once"); // [R7]

  property p_timeout;
    (state_reg == sspc_pkg::ST_HOLD && pin_low && policy == 2'h1 && hold_cnt_reg == 8'h00)
      |=> state_reg == sspc_pkg::ST_OFF && !o_pwr.core_regulator_en;
  endproperty
  a_timeout: assert property (p_timeout) else $error("keep-alive timeout ignored"); // [R8]

  property p_wait_clean;
    (state_reg == sspc_pkg::ST_HOLD && pin_low && policy == 2'h2 && !i_clean_done)
      |=> o_pwr.core_regulator_en && o_pwr.clean_shutdown_req;
  endproperty
  a_wait_clean: assert property (p_wait_clean) else $error("core dropped early"); // [R9]

  property p_hold_time;
    (load_hold && pwrdn_reg.core_supply_hold_time == 2'h3) |=> hold_cnt_reg == 8'h0A;
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("hold count wrong"); // [R10]

  property p_soft_rst;
    soft_rst |=> sleep_reg == 8'h00 && pwrdn_reg == 8'h05;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset missed"); // [R11] [R12]

  property p_tick_hold;
    (!tick && !load_charge && state_reg == sspc_pkg::ST_CHARGE) |=> $stable(vref_cnt_reg);
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("count moved without tick"); // [R13]

  property p_vref_long;
    (load_charge && sleep_reg.reference_precharge_time == 2'h3) |=> vref_cnt_reg == 8'hC8;
  endproperty
  a_vref_long: assert property (p_vref_long) else $error("long vref count wrong"); // [R2]

  property p_incap_short;
    (load_charge && pwrdn_reg.input_cap_precharge_time == 2'h0) |=> incap_cnt_reg == 8'h05;
  endproperty
  a_incap_short: assert property (p_incap_short) else $error("short incap count wrong"); // [R6]

  property p_hold_long;
    (load_hold && pwrdn_reg.core_supply_hold_time == 2'h0) |=> hold_cnt_reg == 8'h3C;
  endproperty
  a_hold_long: assert property (p_hold_long) else $error("long hold count wrong"); // [R10]

  // Reserved policy must never leave the core running on a low pin
  property p_reserved_off;
    (pin_low && policy == 2'h3 && state_reg != sspc_pkg::ST_HOLD) |=> !o_pwr.core_regulator_en;
  endproperty
  a_reserved_off: assert property (p_reserved_off) else $error("policy 3 kept core"); // [R9]

  property p_rsvd_read;
    (i_reg_rd && sel_pwrdn) |=> o_reg_rdata[7:6] == 2'h0;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits read nonzero"); // [R11]

  property p_pin_release;
    (state_reg == sspc_pkg::ST_OFF && !pin_low) |=> o_pwr.core_regulator_en && !o_pwr.awake;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("core not back on"); // [R7]

  property p_charge_end;
    (state_reg == sspc_pkg::ST_CHARGE && charge_done && awake && !pin_low) |=> o_pwr.awake;
  endproperty
  a_charge_end: assert property (p_charge_end) else $error("not awake after precharge"); // [R5]

  c_active: cover property (state_reg == sspc_pkg::ST_CHARGE ##1 state_reg == sspc_pkg::ST_ACTIVE);
  c_timeout: cover property (state_reg == sspc_pkg::ST_HOLD && hold_expired
    ##1 !o_pwr.core_regulator_en);
  c_clean: cover property (state_reg == sspc_pkg::ST_HOLD && i_clean_done && pin_low);
  c_soft: cover property (soft_rst);
endmodule : sspc_power_ctrl

// ===== test/sspc_power_ctrl_tb.sv
`timescale 1ns/10ps
`include "sspc_map.svh"

module sspc_power_ctrl_tb;
  // Short prescaler keeps every duration within 800 cycles
  localparam int TK = 4;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_shutdown_pin_n = 1'b1;
  logic [1:0] i_addr_strap = 2'b10;
  logic i_clean_done = 1'b0;
  logic [7:0] o_reg_rdata;
  logic [6:0] o_i2c_slave_addr;
  sspc_pkg::sspc_pwr_t o_pwr;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int vt[4] = '{7, 20, 100, 200};
  int it[4] = '{5, 25, 50, 100};
  int ht[4] = '{60, 50, 20, 10};

  sspc_power_ctrl #(.TICK_CYC(TK), .STRAP_BASE(5'h0A)) i_sspc_power_ctrl (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_shutdown_pin_n(i_shutdown_pin_n), .i_addr_strap(i_addr_strap),
    .i_clean_done(i_clean_done), .o_i2c_slave_addr(o_i2c_slave_addr), .o_pwr(o_pwr));

  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic summarize();
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // A hang must still end in the verdict
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input int n);
    checks_done++;
    if (n < lo || n > hi) begin
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, n);
      err_total++;
    end
  endtask : chk_rng

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk_sys);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk_sys);
    i_reg_rd = 1'b0;
    chk(nm, exp, o_reg_rdata);
  endtask : rd

  task automatic wait_awake(output int n);
    n = 0;
    while (o_pwr.awake !== 1'b1 && n < 1000) begin
      @(negedge i_clk_sys);
      n++;
    end
  endtask : wait_awake

  task automatic wake(input int k);
    int n;
    int m;
    m = (vt[k] > it[k]) ? vt[k] : it[k];
    wr(`SSPC_OFS_PWRDN, {2'b00, k[1:0], 4'h7});
    wr(`SSPC_OFS_SLEEP, {3'b000, k[1:0], 3'b001});
    repeat (2) @(negedge i_clk_sys);
    chk("vref_charging", 8'h01, {7'h00, o_pwr.vref_charging});
    chk("incap_charging", 8'h01, {7'h00, o_pwr.incap_charging});
    wait_awake(n);
    chk_rng("wake_cycles", m * TK - 2, m * TK + TK + 4, n + 2);
  endtask : wake

  task automatic shut(input logic [1:0] pol, input logic [1:0] hold, input int lo,
                      input int hi, input int done_at);
    int n;
    wr(`SSPC_OFS_PWRDN, {4'h0, pol, hold});
    @(negedge i_clk_sys);
    i_shutdown_pin_n = 1'b0;
    n = 0;
    while (o_pwr.core_regulator_en === 1'b1 && n < 400) begin
      @(negedge i_clk_sys);
      n++;
      if (n == 2) chk("clean_req", {7'h00, (pol == 2'h1 || pol == 2'h2)},
                      {7'h00, o_pwr.clean_shutdown_req});
      if (n == done_at) i_clean_done = 1'b1;
    end
    chk_rng("core_off_cycles", lo, hi, n);
    i_shutdown_pin_n = 1'b1;
    i_clean_done = 1'b0;
    wait_awake(n);
    chk("core_back_on", 8'h01, {7'h00, o_pwr.core_regulator_en});
  endtask : shut

  initial begin
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk("strap_addr", 8'h2A, {1'b0, o_i2c_slave_addr});
    rd("pwrdn_reset", `SSPC_OFS_PWRDN, 8'h05);
    rd("sleep_reset", `SSPC_OFS_SLEEP, 8'h00);
    rd("soft_reset_read", `SSPC_OFS_SOFT_RESET, 8'h00);
    wr(8'h33, 8'hFF);
    rd("unmapped_read", 8'h33, 8'h00);
    chk("asleep", 8'h00, {7'h00, o_pwr.awake});
    wr(`SSPC_OFS_SLEEP, 8'hFE);
    rd("sleep_rw", `SSPC_OFS_SLEEP, 8'hFC);
    chk("supply_sel_on", 8'h01, {7'h00, o_pwr.analog_regulator_source_sel});
    chk("group_addr", 8'h4C, {1'b0, o_i2c_slave_addr});
    wr(`SSPC_OFS_PWRDN, 8'hFF);
    rd("pwrdn_rw", `SSPC_OFS_PWRDN, 8'h3F);
    wr(`SSPC_OFS_SLEEP, 8'h7A);
    rd("sleep_rw2", `SSPC_OFS_SLEEP, 8'h78);
    chk("supply_sel_off", 8'h00, {7'h00, o_pwr.analog_regulator_source_sel});
    chk("strap_addr_back", 8'h2A, {1'b0, o_i2c_slave_addr});
    wr(`SSPC_OFS_SOFT_RESET, 8'h01);
    rd("sleep_soft", `SSPC_OFS_SLEEP, 8'h00);
    rd("pwrdn_soft", `SSPC_OFS_PWRDN, 8'h05);
    for (int k = 0; k < 4; k++) begin
      wake(k);
      wr(`SSPC_OFS_SLEEP, 8'h00);
      repeat (3) @(negedge i_clk_sys);
      chk("back_asleep", 8'h00, {7'h00, o_pwr.awake});
    end
    wake(0);
    shut(2'h0, 2'h0, 0, 2, 0);
    shut(2'h3, 2'h0, 0, 2, 0);
    for (int h = 0; h < 4; h++) begin
      shut(2'h1, h[1:0], ht[h] * TK, ht[h] * TK + TK + 3, 0);
    end
    shut(2'h1, 2'h0, 20, 22, 20);
    shut(2'h2, 2'h0, 300, 302, 300);
    summarize();
  end
endmodule : sspc_power_ctrl_tb
